// *** lamp_chop_dimmer_status.sv ***
module lamp_chop_dimmer_status (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Mode pins
    input wire logic suspend_select_pin,
    input wire logic minimum_level_pin,
    input wire logic open_tube_detect,
    // Lamp control
    output logic shutdown_active,
    output logic switch_enable,
    output logic soft_start_pull_low,
    output logic compensation_node_hiz,
    output logic chop_mode_active,
    output logic [lamp_chop_pkg::CODE_WIDTH-1:0] dac_readback
);
    import lamp_chop_pkg::*;

    chop_if chop ();

    logic [6:0] config_set0;
    logic [6:0] config_set1;
    logic open_tube_flag;
    logic scl_q;
    logic sda_q;
    bus_state_t bus_state;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic read_mode;
    logic [1:0] byte_index;
    logic [6:0] selected;
    logic [CODE_WIDTH-1:0] active_code;
    logic shutdown;
    logic standby;
    logic running;
    logic [7:0] status_readback;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    chop_gen chopper (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .chop(chop.gen)
    );

    // ==========================================================
    // Selected configuration and mode
    always_comb begin
        selected = suspend_select_pin ? config_set1 : config_set0;
        active_code = selected[CODE_MSB:0];
        shutdown = !selected[SHUTDOWN_POS];
        standby = !selected[STANDBY_POS];
        running = !shutdown && !standby;
        status_readback = {open_tube_flag, UNUSED_STATUS_BITS, active_code};
    end

    assign chop.code = active_code;

    // ==========================================================
    // Lamp drive outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shutdown_active <= 1'b0;
            switch_enable <= 1'b0;
            soft_start_pull_low <= 1'b1;
            compensation_node_hiz <= 1'b1;
            chop_mode_active <= 1'b0;
            dac_readback <= '0;
        end else begin
            shutdown_active <= shutdown;
            chop_mode_active <= minimum_level_pin;
            dac_readback <= active_code;
            if (!running) begin
                switch_enable <= 1'b0;
                soft_start_pull_low <= 1'b1;
                compensation_node_hiz <= 1'b1;
            end else if (minimum_level_pin) begin
                switch_enable <= chop.on_time;
                soft_start_pull_low <= !chop.on_time;
                compensation_node_hiz <= !chop.on_time;
            end else begin
                // Current scaling mode: lamp stays on, code steers current
                switch_enable <= 1'b1;
                soft_start_pull_low <= 1'b0;
                compensation_node_hiz <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Open-tube flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            open_tube_flag <= 1'b1;
        end else if (open_tube_detect) begin
            // Detection wins over a restore in the same cycle
            open_tube_flag <= 1'b0;
        end else if (!running) begin
            open_tube_flag <= 1'b1;
        end
    end

    // ==========================================================
    // Bus line edges
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_comb begin
        scl_rise = scl_in && !scl_q;
        scl_fall = !scl_in && scl_q;
        bus_start = scl_in && scl_q && sda_q && !sda_in;
        bus_stop = scl_in && scl_q && !sda_q && sda_in;
    end

    // ==========================================================
    // Serial slave; never gated by shutdown
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_state <= BUS_IDLE;
            bit_count <= '0;
            shift <= '0;
            read_mode <= 1'b0;
            byte_index <= '0;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            bus_state <= BUS_ADDRESS;
            bit_count <= '0;
            byte_index <= '0;
            sda_oe <= 1'b0;
        end else if (bus_stop) begin
            bus_state <= BUS_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    sda_oe <= 1'b0;
                end
                BUS_ADDRESS, BUS_RECEIVE: begin
                    if (scl_rise && bit_count < BITS_PER_BYTE) begin
                        shift <= {shift[6:0], sda_in};
                        bit_count <= bit_count + 1'b1;
                    end else if (scl_fall && bit_count == BITS_PER_BYTE) begin
                        if (bus_state == BUS_RECEIVE) begin
                            sda_oe <= 1'b1;
                            bus_state <= BUS_ACK;
                            // Saturate so bytes after the config byte are ignored
                            if (byte_index != 2'h3) begin
                                byte_index <= byte_index + 1'b1;
                            end
                        end else if (shift[7:1] == SLAVE_ADDRESS) begin
                            read_mode <= shift[0];
                            sda_oe <= 1'b1;
                            bus_state <= BUS_ACK;
                        end else begin
                            bus_state <= BUS_IDLE;
                        end
                    end
                end
                BUS_ACK: begin
                    if (scl_fall) begin
                        bit_count <= '0;
                        if (read_mode) begin
                            // Status captured at the start of each data byte
                            shift <= {status_readback[6:0], 1'b0};
                            sda_oe <= !status_readback[7];
                            bit_count <= 4'h1;
                            bus_state <= BUS_TRANSMIT;
                        end else begin
                            sda_oe <= 1'b0;
                            bus_state <= BUS_RECEIVE;
                        end
                    end
                end
                BUS_TRANSMIT: begin
                    if (scl_fall) begin
                        if (bit_count == BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            bus_state <= BUS_TRANSMIT_ACK;
                        end else begin
                            sda_oe <= !shift[7];
                            shift <= {shift[6:0], 1'b0};
                            bit_count <= bit_count + 1'b1;
                        end
                    end
                end
                BUS_TRANSMIT_ACK: begin
                    if (scl_rise) begin
                        // Host acknowledge asks for another status byte
                        bus_state <= sda_in ? BUS_IDLE : BUS_ACK;
                    end
                end
            endcase
        end
    end

    // Open-drain: only ever drives low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration sets, written by the byte after the command
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            config_set0 <= CONFIG_RESET;
            config_set1 <= CONFIG_RESET;
        end else if (bus_state == BUS_RECEIVE && scl_fall && bit_count == BITS_PER_BYTE
                     && byte_index == CONFIG_BYTE_INDEX) begin
            if (shift[SET_SELECT_POS]) begin
                config_set1 <= shift[6:0];
            end else begin
                config_set0 <= shift[6:0];
            end
        end
    end

endmodule

// *** lamp_chop_pkg.sv ***
package lamp_chop_pkg;

    // ==========================================================
    // Configuration byte layout
    localparam int SET_SELECT_POS = 7;
    localparam int SHUTDOWN_POS = 6;
    localparam int STANDBY_POS = 5;
    localparam int CODE_MSB = 4;
    localparam int CODE_WIDTH = 5;

    // ==========================================================
    // Values after reset for both configuration sets
    localparam logic [6:0] CONFIG_RESET = 7'h70;

    // ==========================================================
    // Status byte layout
    localparam int OPEN_TUBE_POS = 7;
    localparam logic [1:0] UNUSED_STATUS_BITS = 2'h3;

    // ==========================================================
    // Serial interface
    // Arbitrary default bus address
    localparam logic [6:0] SLAVE_ADDRESS = 7'h2C;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] CONFIG_BYTE_INDEX = 2'h1;

    // ==========================================================
    // Chopping
    localparam int CHOP_PERIOD = 1024;
    localparam int CHOP_COUNT_WIDTH = 10;
    localparam int THRESHOLD_WIDTH = 11;
    localparam logic [THRESHOLD_WIDTH-1:0] THRESHOLD_STEP = 11'h021;
    localparam logic [THRESHOLD_WIDTH-1:0] THRESHOLD_MIN = 11'h063;
    localparam logic [THRESHOLD_WIDTH-1:0] THRESHOLD_FULL = 11'h400;
    localparam logic [CODE_WIDTH-1:0] CODE_FULL = 5'h1F;
    localparam logic [CODE_WIDTH-1:0] CODE_MIN_LIMIT = 5'h03;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDRESS,
        BUS_ACK,
        BUS_RECEIVE,
        BUS_TRANSMIT,
        BUS_TRANSMIT_ACK
    } bus_state_t;

endpackage

// *** chop_if.sv ***
interface chop_if;
    import lamp_chop_pkg::*;

    logic [CODE_WIDTH-1:0] code;
    logic on_time;

    modport gen (
        input code,
        output on_time
    );

    modport user (
        output code,
        input on_time
    );
endinterface

// *** chop_gen.sv ***
module chop_gen (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Brightness in, on-time out
    chop_if.gen chop
);
    import lamp_chop_pkg::*;

    logic [CHOP_COUNT_WIDTH-1:0] count;

    // ==========================================================
    // Threshold from brightness code
    function automatic logic [THRESHOLD_WIDTH-1:0] threshold(
        input logic [CODE_WIDTH-1:0] code
    );
        logic [THRESHOLD_WIDTH-1:0] product;
        product = THRESHOLD_STEP * THRESHOLD_WIDTH'(code);
        if (code == '0) begin
            threshold = '0;
        end else if (code <= CODE_MIN_LIMIT) begin
            threshold = THRESHOLD_MIN;
        end else if (code == CODE_FULL) begin
            threshold = THRESHOLD_FULL;
        end else begin
            threshold = product;
        end
    endfunction

    // ==========================================================
    // Free-running period counter, wraps every 1024 cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chop.on_time <= 1'b0;
        end else begin
            chop.on_time <= THRESHOLD_WIDTH'(count) < threshold(chop.code);
        end
    end

endmodule

// *** lamp_chop_props.sv ***
module lamp_chop_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Pins
    input wire logic suspend_select_pin,
    input wire logic minimum_level_pin,
    input wire logic open_tube_detect,
    // Lamp
    input wire logic shutdown_active,
    input wire logic switch_enable,
    input wire logic soft_start_pull_low,
    input wire logic compensation_node_hiz,
    input wire logic chop_mode_active,
    input wire logic [lamp_chop_pkg::CODE_WIDTH-1:0] dac_readback
);
    timeunit 1ns;
    timeprecision 100ps;
    import lamp_chop_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // On-time run length, restarted whenever the code moves
    logic [10:0] on_len;
    logic [10:0] thr;
    always_comb begin
        thr = dac_readback == 5'h00 ? 11'h000 : dac_readback < 5'h04 ? 11'h063 :
            11'(dac_readback) * 11'h021;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !switch_enable || !chop_mode_active || dac_readback != $past(dac_readback)) begin
            on_len <= 11'h000;
        end else begin
            on_len <= on_len + 11'h001;
        end
    end
    // ==========================================================
    // Assertions
    chk_offtime_pair: assert property (soft_start_pull_low == compensation_node_hiz)
        else $error("soft-start and compensation release differ");
    chk_switch_off: assert property (soft_start_pull_low |-> !switch_enable)
        else $error("switch on during off-time");
    chk_shutdown_off: assert property (shutdown_active [*3] |-> !switch_enable && soft_start_pull_low)
        else $error("lamp running in shutdown");
    chk_mode_copy: assert property ($past(rst_n) |-> chop_mode_active == $past(minimum_level_pin))
        else $error("mode does not follow strap");
    chk_zero_code: assert property ((chop_mode_active && dac_readback == 5'h00) [*4] |-> !switch_enable)
        else $error("switch on with code zero");
    // Run length restarts one cycle after a code change, so skip that cycle
    chk_on_bound: assert property (chop_mode_active && dac_readback != 5'h1F && $stable(dac_readback)
        |-> on_len <= thr + 11'h003)
        else $error("on-time longer than code allows");
    chk_sda_low: assert property (!sda_out)
        else $error("data pin driven high");
    chk_oe_rise: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data pulled low while bus clock high");
    cover property (shutdown_active);
    cover property ($rose(sda_oe));
    cover property (chop_mode_active && $fell(switch_enable));
endmodule

bind lamp_chop_dimmer_status lamp_chop_props i_lamp_chop_props (
    .sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .suspend_select_pin,
    .minimum_level_pin, .open_tube_detect, .shutdown_active, .switch_enable,
    .soft_start_pull_low, .compensation_node_hiz, .chop_mode_active, .dac_readback
);

// *** smbus_host_model.sv ***
module smbus_host_model (
    // Clock and resolved data line
    input wire logic sys_clk,
    input wire logic sda_line,
    // Host drive
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    import lamp_chop_pkg::*;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Four clocks a half bit, above the three the receiver needs
    task automatic hp();
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic bit_x(input logic b, output logic seen);
        sda_low = !b;
        hp();
        scl = 1'b1;
        hp();
        seen = sda_line;
        scl = 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(1'b1, nak);
    endtask
    // Start falls, stop rises, both with the bus clock high
    task automatic edge_s(input logic stop);
        sda_low = stop;
        hp();
        scl = 1'b1;
        hp();
        sda_low = !stop;
        hp();
        scl = stop;
    endtask
    task automatic read_status(output logic [7:0] st, output logic nak);
        logic [7:0] dump;
        edge_s(1'b0);
        byte_x({SLAVE_ADDRESS, 1'b1}, dump, nak);
        byte_x(8'hFF, st, dump[0]);
        edge_s(1'b1);
    endtask
    task automatic write_cfg(input logic [6:0] a, input logic [7:0] cfg, output logic nak);
        logic [7:0] dump;
        logic n1;
        logic n2;
        edge_s(1'b0);
        byte_x({a, 1'b0}, dump, nak);
        byte_x(8'h00, dump, n1);
        byte_x(cfg, dump, n2);
        nak = nak | n1 | n2;
        edge_s(1'b1);
    endtask
endmodule

// *** tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import lamp_chop_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl_in;
    logic sda_low;
    logic suspend_select_pin = 1'b0;
    logic minimum_level_pin = 1'b1;
    logic open_tube_detect = 1'b0;
    logic sda_oe, sda_out, shutdown_active, switch_enable, soft_start_pull_low;
    logic compensation_node_hiz, chop_mode_active;
    logic [CODE_WIDTH-1:0] dac_readback;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [15:0] rnd = 16'hBE2E;
    logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10, 5'h1E, 5'h1F};
    // Open-drain wire with pull-up
    wire sda_in = !(sda_oe === 1'b1 || sda_low);
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    lamp_chop_dimmer_status i_lamp_chop_dimmer_status (
        .sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .suspend_select_pin,
        .minimum_level_pin, .open_tube_detect, .shutdown_active, .switch_enable,
        .soft_start_pull_low, .compensation_node_hiz, .chop_mode_active, .dac_readback
    );
    smbus_host_model i_smbus_host_model (.sys_clk, .sda_line(sda_in), .scl(scl_in), .sda_low);
    // ==========================================================
    // Expectations
    function automatic int thr(input logic [4:0] c);
        return c == 0 ? 0 : c < 4 ? 99 : c == 31 ? 1024 : 33 * c;
    endfunction
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] e);
        logic [7:0] st;
        logic nak;
        i_smbus_host_model.read_status(st, nak);
        `CHK("read ack", 1'b0, nak)
        `CHK("status", e, st)
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c);
        logic nak;
        i_smbus_host_model.write_cfg(a, c, nak);
        `CHK("write ack", a != SLAVE_ADDRESS, nak)
        repeat (4) @(negedge sys_clk);
    endtask
    // Two whole periods in any phase hold twice the on-time, and two rises unless the code is 00 or 1F
    task automatic chop(input logic [4:0] c);
        int hi;
        int rises;
        int lo;
        logic prev;
        hi = 0;
        rises = 0;
        lo = 0;
        wr(SLAVE_ADDRESS, {3'b111, c});
        `CHK("code", c, dac_readback)
        prev = switch_enable;
        repeat (2048) begin
            @(negedge sys_clk);
            hi += int'(switch_enable);
            lo += int'(soft_start_pull_low) + int'(compensation_node_hiz);
            rises += int'(switch_enable && !prev);
            prev = switch_enable;
        end
        `CHK("on cycles", 2 * thr(c), hi)
        `CHK("rises", (thr(c) % 1024 != 0) ? 2 : 0, rises)
        `CHK("off cycles", 2 * (2048 - 2 * thr(c)), lo)
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        rd(8'hF0);
        wr(SLAVE_ADDRESS, 8'h05);
        `CHK("shutdown", 1'b1, shutdown_active)
        rd(8'hE5);
        wr(SLAVE_ADDRESS, 8'h65);
        `CHK("shutdown", 1'b0, shutdown_active)
        wr(SLAVE_ADDRESS ^ 7'h01, 8'h45);
        `CHK("shutdown", 1'b0, shutdown_active)
        suspend_select_pin = 1'b1;
        foreach (codes[i]) begin
            chop(codes[i]);
        end
        repeat (3) begin
            rnd = lfsr(rnd);
            chop(rnd[4:0]);
        end
        open_tube_detect = 1'b1;
        @(negedge sys_clk);
        open_tube_detect = 1'b0;
        rd({3'b011, rnd[4:0]});
        wr(SLAVE_ADDRESS, 8'h90);
        rd(8'hF0);
        wr(SLAVE_ADDRESS, 8'hF0);
        minimum_level_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK("chop mode", 1'b0, chop_mode_active)
        `CHK("switch", 1'b1, switch_enable)
        suspend_select_pin = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK("code", 5'h05, dac_readback)
        // Reset in mid-run returns both sets to their defaults
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK("reset switch", 1'b0, switch_enable)
        `CHK("reset pull", 1'b1, soft_start_pull_low)
        `CHK("reset hiz", 1'b1, compensation_node_hiz)
        rst_n = 1'b1;
        @(negedge sys_clk);
        rd(8'hF0);
        complete_run();
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            complete_run();
        end
    end
endmodule
